// File: core/pird_pkg.sv
// Constants for the peripheral I/O register decode block
package pird_pkg;

  // Bus widths
  localparam int IO_ADDR_W  = 16;
  localparam int BUS_ADDR_W = 24;
  localparam int DATA_W     = 8;
  localparam int CS_W       = 4;

  // Counts of register groups and the timer count width
  localparam int NUM_TMR      = 6;
  localparam int NUM_PORT     = 3;
  localparam int NUM_ALT_PORT = 2;
  localparam int TMR_CNT_W    = 16;

  // Peripheral window bounds
  localparam logic [15:0] WIN_LO = 16'h0080;
  localparam logic [15:0] WIN_HI = 16'h00FF;

  // Upper address byte presented during I/O cycles (undefined, driven low)
  localparam logic [7:0] IO_ADDR_UPPER = 8'h00;

  // Timer register addresses, timer 0 first
  localparam logic [15:0] TMR_CTL_ADDR [NUM_TMR] =
    '{16'h0800, 16'h0083, 16'h0086, 16'h0089, 16'h008C, 16'h008F};
  localparam logic [15:0] TMR_LO_ADDR [NUM_TMR] =
    '{16'h0081, 16'h0084, 16'h0087, 16'hA800, 16'h008D, 16'h0090};
  localparam logic [15:0] TMR_HI_ADDR [NUM_TMR] =
    '{16'h0082, 16'h0085, 16'h0088, 16'h008B, 16'h008E, 16'h0091};

  // Shared timer and watchdog addresses
  localparam logic [15:0] TIMER_INPUT_SOURCE_SELECT_ADDR = 16'h0092;
  localparam logic [15:0] WATCHDOG_CONTROL_ADDR = 16'h0093;
  localparam logic [15:0] WATCHDOG_RESTART_ADDR  = 16'h0094;

  // Port register addresses, port B first
  localparam logic [15:0] PORT_DATA_ADDR [NUM_PORT] = '{16'h009A, 16'h009E, 16'h00A2};
  localparam logic [15:0] PORT_DIR_ADDR  [NUM_PORT] = '{16'h009B, 16'h009F, 16'h00A3};
  localparam logic [15:0] PORT_ALT1_ADDR [NUM_ALT_PORT] = '{16'h009C, 16'h00A0};
  localparam logic [15:0] PORT_ALT2_ADDR [NUM_ALT_PORT] = '{16'h009D, 16'h00A1};

  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'hFF;
  localparam logic [7:0] WATCHDOG_CONTROL_RST_0 = 8'h00;
  localparam logic [7:0] WATCHDOG_CONTROL_RST_1 = 8'h20;
  localparam logic [7:0] DATA_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_RD   = 8'h00;

endpackage

// File: core/pird_io_decode.sv
// Peripheral I/O window decode and register bank
`timescale 1ns/1ps

module pird_io_decode (
  input  wire logic                                          clk_sys,
  input  wire logic                                          rst_n,
  // Processor I/O request, one-cycle strobe
  input  wire logic                                          io_req,
  input  wire logic                                          io_wr,
  input  wire logic [pird_pkg::IO_ADDR_W-1:0]                io_addr,
  input  wire logic [pird_pkg::DATA_W-1:0]                   io_wdata,
  // Chip select range hits from the chip select comparators
  input  wire logic [pird_pkg::CS_W-1:0]                     ext_cs_hit,
  // Watchdog reset-value strap pin
  input  wire logic                                          wdt_rst_strap,
  // Live timer counts, timer 0 in the low bits
  input  wire logic [pird_pkg::NUM_TMR*pird_pkg::TMR_CNT_W-1:0] tmr_count,
  // Read answer
  output logic [pird_pkg::DATA_W-1:0]                        io_rdata_q,
  output logic                                               io_rvalid_q,
  output logic                                               io_int_hit_q,
  // External bus side
  output logic [pird_pkg::BUS_ADDR_W-1:0]                    bus_addr_q,
  output logic [pird_pkg::CS_W-1:0]                          ext_cs_q,
  // Timer controls
  output logic [pird_pkg::NUM_TMR*pird_pkg::DATA_W-1:0]      tmr_ctl_q,
  output logic [pird_pkg::NUM_TMR*pird_pkg::TMR_CNT_W-1:0]   tmr_reload_q,
  output logic [pird_pkg::NUM_TMR-1:0]                       tmr_reload_wr_q,
  output logic [pird_pkg::DATA_W-1:0]                        timer_input_source_select_q,
  // Watchdog
  output logic [pird_pkg::DATA_W-1:0]                        watchdog_control_q,
  output logic                                               wdt_restart_q,
  output logic [pird_pkg::DATA_W-1:0]                        wdt_restart_data_q,
  // General-purpose ports, port B in the low bits
  output logic [pird_pkg::NUM_PORT*pird_pkg::DATA_W-1:0]     port_data_q,
  output logic [pird_pkg::NUM_PORT*pird_pkg::DATA_W-1:0]     port_dir_q,
  output logic [pird_pkg::NUM_ALT_PORT*pird_pkg::DATA_W-1:0] port_alt1_q,
  output logic [pird_pkg::NUM_ALT_PORT*pird_pkg::DATA_W-1:0] port_alt2_q
);

  localparam int DW = pird_pkg::DATA_W;
  localparam int CW = pird_pkg::TMR_CNT_W;

  // Internal target test: the window plus the two stray timer addresses
  function automatic logic is_internal(input logic [15:0] a);
    logic hit;
    hit = (a >= pird_pkg::WIN_LO) && (a <= pird_pkg::WIN_HI);
    hit = hit || (a == pird_pkg::TMR_CTL_ADDR[0]) || (a == pird_pkg::TMR_LO_ADDR[3]);
    return hit;
  endfunction

  logic                 int_hit;
  logic                 wr_hit;
  logic                 rd_hit;
  logic                 strap_meta_q;
  logic                 strap_sync_q;
  logic [DW-1:0]        rd_mux;

  // Only I/O cycles reach this block; full 16-bit compare throughout
  assign int_hit = io_req && is_internal(io_addr);
  assign wr_hit  = int_hit && io_wr;
  assign rd_hit  = int_hit && !io_wr;

  // Strap synchroniser, free-running so it is settled before reset releases
  always_ff @(posedge clk_sys) begin
    strap_meta_q <= wdt_rst_strap;
    strap_sync_q <= strap_meta_q;
  end

  // External address on every request; chip select suppressed on internal hits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_addr_q   <= '0;
      ext_cs_q     <= '0;
      io_int_hit_q <= 1'b0;
    end else begin
      io_int_hit_q <= int_hit;
      if (io_req) begin
        bus_addr_q <= {pird_pkg::IO_ADDR_UPPER, io_addr};
      end
      ext_cs_q <= (io_req && !int_hit) ? ext_cs_hit : '0;
    end
  end

  // Per-timer control and reload registers
  for (genvar t = 0; t < pird_pkg::NUM_TMR; t++) begin : g_tmr
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        tmr_ctl_q[t*DW +: DW]          <= pird_pkg::RST_ZERO;
        tmr_reload_q[t*CW +: DW]       <= pird_pkg::RST_ZERO;
        tmr_reload_q[t*CW + DW +: DW]  <= pird_pkg::RST_ZERO;
        tmr_reload_wr_q[t]             <= 1'b0;
      end else begin
        tmr_reload_wr_q[t] <= 1'b0;
        if (wr_hit && io_addr == pird_pkg::TMR_CTL_ADDR[t]) begin
          tmr_ctl_q[t*DW +: DW] <= io_wdata;
        end
        if (wr_hit && io_addr == pird_pkg::TMR_LO_ADDR[t]) begin
          tmr_reload_q[t*CW +: DW] <= io_wdata;
          tmr_reload_wr_q[t]       <= 1'b1;
        end
        if (wr_hit && io_addr == pird_pkg::TMR_HI_ADDR[t]) begin
          tmr_reload_q[t*CW + DW +: DW] <= io_wdata;
          tmr_reload_wr_q[t]            <= 1'b1;
        end
      end
    end
  end

  // Timer input source select
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timer_input_source_select_q <= pird_pkg::RST_ZERO;
    end else if (wr_hit && io_addr == pird_pkg::TIMER_INPUT_SOURCE_SELECT_ADDR) begin
      timer_input_source_select_q <= io_wdata;
    end
  end

  // Watchdog control, reset value chosen by the synchronised strap
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      watchdog_control_q <= strap_sync_q ? pird_pkg::WATCHDOG_CONTROL_RST_1 : pird_pkg::WATCHDOG_CONTROL_RST_0;
    end else if (wr_hit && io_addr == pird_pkg::WATCHDOG_CONTROL_ADDR) begin
      watchdog_control_q <= io_wdata;
    end
  end

  // Watchdog restart: write strobe with the written byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdt_restart_q      <= 1'b0;
      wdt_restart_data_q <= pird_pkg::RST_ZERO;
    end else begin
      wdt_restart_q <= wr_hit && (io_addr == pird_pkg::WATCHDOG_RESTART_ADDR);
      if (wr_hit && io_addr == pird_pkg::WATCHDOG_RESTART_ADDR) begin
        wdt_restart_data_q <= io_wdata;
      end
    end
  end

  // Port data and direction registers
  for (genvar p = 0; p < pird_pkg::NUM_PORT; p++) begin : g_port
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        port_data_q[p*DW +: DW] <= pird_pkg::DATA_RST;
        port_dir_q[p*DW +: DW]  <= pird_pkg::DIR_RST;
      end else begin
        if (wr_hit && io_addr == pird_pkg::PORT_DATA_ADDR[p]) begin
          port_data_q[p*DW +: DW] <= io_wdata;
        end
        if (wr_hit && io_addr == pird_pkg::PORT_DIR_ADDR[p]) begin
          port_dir_q[p*DW +: DW] <= io_wdata;
        end
      end
    end
  end

  // Port alternate-function registers
  for (genvar p = 0; p < pird_pkg::NUM_ALT_PORT; p++) begin : g_alt
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        port_alt1_q[p*DW +: DW] <= pird_pkg::RST_ZERO;
        port_alt2_q[p*DW +: DW] <= pird_pkg::RST_ZERO;
      end else begin
        if (wr_hit && io_addr == pird_pkg::PORT_ALT1_ADDR[p]) begin
          port_alt1_q[p*DW +: DW] <= io_wdata;
        end
        if (wr_hit && io_addr == pird_pkg::PORT_ALT2_ADDR[p]) begin
          port_alt2_q[p*DW +: DW] <= io_wdata;
        end
      end
    end
  end
  // Unassigned addresses match none of the compares above, so writes are dropped

  // Read multiplexer; unassigned and write-only addresses read as a fixed byte
  always_comb begin
    rd_mux = pird_pkg::UNMAPPED_RD;
    for (int t = 0; t < pird_pkg::NUM_TMR; t++) begin
      if (io_addr == pird_pkg::TMR_CTL_ADDR[t]) rd_mux = tmr_ctl_q[t*DW +: DW];
      if (io_addr == pird_pkg::TMR_LO_ADDR[t])  rd_mux = tmr_count[t*CW +: DW];
      if (io_addr == pird_pkg::TMR_HI_ADDR[t])  rd_mux = tmr_count[t*CW + DW +: DW];
    end
    if (io_addr == pird_pkg::TIMER_INPUT_SOURCE_SELECT_ADDR) rd_mux = timer_input_source_select_q;
    if (io_addr == pird_pkg::WATCHDOG_CONTROL_ADDR) rd_mux = watchdog_control_q;
    for (int p = 0; p < pird_pkg::NUM_PORT; p++) begin
      if (io_addr == pird_pkg::PORT_DATA_ADDR[p]) rd_mux = port_data_q[p*DW +: DW];
      if (io_addr == pird_pkg::PORT_DIR_ADDR[p])  rd_mux = port_dir_q[p*DW +: DW];
    end
    for (int p = 0; p < pird_pkg::NUM_ALT_PORT; p++) begin
      if (io_addr == pird_pkg::PORT_ALT1_ADDR[p]) rd_mux = port_alt1_q[p*DW +: DW];
      if (io_addr == pird_pkg::PORT_ALT2_ADDR[p]) rd_mux = port_alt2_q[p*DW +: DW];
    end
  end

  // Registered read answer, one cycle after an internal read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      io_rdata_q  <= pird_pkg::RST_ZERO;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= rd_hit;
      if (rd_hit) begin
        io_rdata_q <= rd_mux;
      end
    end
  end

endmodule // pird_io_decode

// File: bench/pird_io_decode_assertions.sv
// Concurrent checks on the ports of the peripheral I/O register decode block
`timescale 1ns/1ps
module pird_io_decode_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        io_req,
  input wire logic        io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [3:0]  ext_cs_hit,
  input wire logic        io_rvalid_q,
  input wire logic        io_int_hit_q,
  input wire logic [23:0] bus_addr_q,
  input wire logic [3:0]  ext_cs_q,
  input wire logic [95:0] tmr_reload_q,
  input wire logic [5:0]  tmr_reload_wr_q,
  input wire logic        wdt_restart_q,
  input wire logic [23:0] port_data_q,
  input wire logic [23:0] port_dir_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic hit;
  // Window plus the two out-of-window timer addresses count as internal
  assign hit = (io_addr >= 16'h0080 && io_addr <= 16'h00FF) || io_addr == 16'h0800
               || io_addr == 16'hA800;
  AST_READ_ANSWER: assert property (io_req && !io_wr && hit |=> io_rvalid_q && io_int_hit_q)
    else $error("internal read not answered");
  AST_EXT_SILENT: assert property (io_req && !hit |=> !io_rvalid_q && !io_int_hit_q)
    else $error("external cycle answered internally");
  AST_CS_SUPPRESS: assert property (io_req && hit |=> ext_cs_q == 4'h0)
    else $error("chip select during window hit");
  AST_CS_PASS: assert property (io_req && !hit |=> ext_cs_q == $past(ext_cs_hit))
    else $error("chip select not passed on");
  AST_IO_ADDR: assert property (io_req |=> bus_addr_q[15:0] == $past(io_addr))
    else $error("I/O address not presented");
  AST_RESTART: assert property (io_req && io_wr && io_addr == 16'h0094 |=> wdt_restart_q)
    else $error("restart write lost");
  AST_RELOAD_LO: assert property (io_req && io_wr && io_addr == 16'h0081 |=>
    tmr_reload_wr_q == 6'h01 && tmr_reload_q[7:0] == $past(io_wdata))
    else $error("reload low byte not loaded");
  AST_UNMAPPED_WR: assert property (io_req && io_wr && io_addr == 16'h00FF |=>
    $stable(port_data_q) && $stable(port_dir_q) && $stable(tmr_reload_q) && !wdt_restart_q)
    else $error("unassigned write changed state");
  AST_ONE_BYTE: assert property (!io_req |=> !io_rvalid_q && !io_int_hit_q)
    else $error("answer without request");
  // Main traffic kinds
  COV_READ: cover property (io_req && !io_wr && hit ##1 io_rvalid_q);
  COV_EXT: cover property (io_req && !hit ##1 ext_cs_q != 4'h0);
  COV_HIT_OVERLAP: cover property (io_req && hit && ext_cs_hit != 4'h0);
endmodule // pird_io_decode_checker

// File: bench/pird_cpu_model.sv
// Processor-side model issuing byte-wide I/O cycles
`timescale 1ns/1ps
module pird_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  io_rdata_q,
  input  wire logic        io_rvalid_q,
  output logic             io_req,
  output logic [15:0]      io_addr,
  output logic             io_wr,
  output logic [7:0]       io_wdata
);
  // Idle bus at time zero
  initial begin
    io_req = 1'b0;
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // One byte per request; called at a falling edge, answer taken at the next falling edge
  task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic v);
    io_req = 1'b1;
    io_wr = w;
    io_addr = a;
    io_wdata = d;
    @(negedge clk_sys);
    r = io_rdata_q;
    v = io_rvalid_q;
  endtask
  // Released address and data lines show the inverse of their last value, never a stale copy
  task automatic idle();
    io_req = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
    @(negedge clk_sys);
  endtask
endmodule // pird_cpu_model

// File: bench/pird_io_decode_test.sv
// Self-checking bench for the peripheral I/O register decode block
`timescale 1ns/1ps
module pird_io_decode_test;
  logic        clk_sys, rst_n, io_req, io_wr, io_rvalid_q, rv, strap;
  logic [15:0] io_addr, a;
  logic [7:0]  io_wdata, io_rdata_q, rd, d;
  logic [3:0]  ext_cs_hit, ext_cs_q, h, j;
  logic [23:0] bus_addr_q;
  logic [95:0] tmr_count, tmr_reload_q;
  integer      err_total = 0, tests_run = 0, seed = 32'h37D56023, k;
  logic [15:0] ra [15] = '{16'h009B, 16'h009F, 16'h00A3, 16'h009C, 16'h009D, 16'h00A0,
    16'h00A1, 16'h0092, 16'h0800, 16'h0083, 16'h008F, 16'h0093, 16'h009A, 16'h009E, 16'h00A2};
  logic [7:0]  sh [15] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  pird_io_decode dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req), .io_wr(io_wr),
    .io_addr(io_addr), .io_wdata(io_wdata), .ext_cs_hit(ext_cs_hit), .wdt_rst_strap(strap),
    .tmr_count(tmr_count), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
    .io_int_hit_q(), .bus_addr_q(bus_addr_q), .ext_cs_q(ext_cs_q), .tmr_ctl_q(),
    .tmr_reload_q(tmr_reload_q), .tmr_reload_wr_q(), .timer_input_source_select_q(), .watchdog_control_q(),
    .wdt_restart_q(), .wdt_restart_data_q(), .port_data_q(), .port_dir_q(),
    .port_alt1_q(), .port_alt2_q());
  pird_cpu_model cpu_u (.clk_sys(clk_sys), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
    .io_req(io_req), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata));
  // Compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard
  initial begin
    #40000;
    err_total++;
    summarize();
  end
  // Main sequence, requests back to back
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    ext_cs_hit = 4'h0;
    tmr_count = {$random(seed), $random(seed), $random(seed)};
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    for (k = 0; k < 12; k++) begin
      cpu_u.cycle(1'b0, ra[k], 8'h00, rd, rv);
      chk(24'({rv, rd}), 24'({1'b1, sh[k]}));
    end
    // Timer reads give live counts, writes load reload bytes
    for (k = 0; k < 6; k++) begin
      cpu_u.cycle(1'b0, pird_pkg::TMR_LO_ADDR[k], 8'h00, rd, rv);
      chk(24'({rv, rd}), 24'({1'b1, tmr_count[16*k +: 8]}));
      cpu_u.cycle(1'b0, pird_pkg::TMR_HI_ADDR[k], 8'h00, rd, rv);
      chk(24'({rv, rd}), 24'({1'b1, tmr_count[16*k+8 +: 8]}));
      a = $random(seed);
      cpu_u.cycle(1'b1, pird_pkg::TMR_LO_ADDR[k], a[7:0], rd, rv);
      cpu_u.cycle(1'b1, pird_pkg::TMR_HI_ADDR[k], a[15:8], rd, rv);
      chk(24'(tmr_reload_q[16*k +: 16]), 24'(a));
    end
    // Fill every read/write register except the timer 2 to 4 controls, then random write and read-back pairs
    for (k = 0; k < 40; k++) begin
      j = (k < 15) ? 4'(k) : 4'($unsigned($random(seed)) % 15);
      d = $random(seed);
      sh[j] = d;
      cpu_u.cycle(1'b1, ra[j], d, rd, rv);
      cpu_u.cycle(1'b0, ra[j], 8'h00, rd, rv);
      chk(24'({rv, rd}), 24'({1'b1, d}));
    end
    // Unassigned and write-only places leave the register file alone
    cpu_u.cycle(1'b1, 16'h00FF, 8'hA5, rd, rv);
    cpu_u.cycle(1'b1, 16'h0095, 8'h5A, rd, rv);
    cpu_u.cycle(1'b1, 16'h0094, 8'hC3, rd, rv);
    cpu_u.cycle(1'b0, 16'h00FF, 8'h00, rd, rv);
    chk(24'(rv), 24'h000001);
    for (k = 0; k < 15; k++) begin
      cpu_u.cycle(1'b0, ra[k], 8'h00, rd, rv);
      chk(24'({rv, rd}), 24'({1'b1, sh[k]}));
    end
    // Odd passes hit the window with chip selects armed, even passes go outside
    for (k = 0; k < 16; k++) begin
      a = $random(seed);
      a[15:12] = 4'h4;
      a = k[0] ? {9'h001, a[6:0]} : a;
      h = $random(seed);
      ext_cs_hit = h;
      cpu_u.cycle(1'b0, a, 8'h00, rd, rv);
      chk(24'(ext_cs_q), k[0] ? 24'h0 : 24'(h));
      chk(bus_addr_q[15:0], 24'(a));
      chk(24'(rv), 24'(k[0]));
    end
    // Mid-run reset with the strap low selects the other watchdog reset value
    cpu_u.idle();
    rst_n = 1'b0;
    strap = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    cpu_u.cycle(1'b0, 16'h0093, 8'h00, rd, rv);
    chk(24'({rv, rd}), 24'h000100);
    cpu_u.cycle(1'b0, 16'h009B, 8'h00, rd, rv);
    chk(24'({rv, rd}), 24'h0001FF);
    cpu_u.idle();
    summarize();
  end
endmodule // pird_io_decode_test

bind pird_io_decode pird_io_decode_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .io_req(io_req), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
  .ext_cs_hit(ext_cs_hit), .io_rvalid_q(io_rvalid_q), .io_int_hit_q(io_int_hit_q),
  .bus_addr_q(bus_addr_q), .ext_cs_q(ext_cs_q), .tmr_reload_q(tmr_reload_q),
  .tmr_reload_wr_q(tmr_reload_wr_q), .wdt_restart_q(wdt_restart_q),
  .port_data_q(port_data_q), .port_dir_q(port_dir_q));
